/* src/csb_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module csb_exec
   import csb_pkg::*;
(
   input wire logic i_clk,            // Core clock, 100 MHz
   input wire logic i_rst_n,          // Async reset, active low
   input wire logic i_valid,          // Instruction presented this cycle
   input wire csb_op_e i_op,          // Operation selector
   input wire csb_opd_e i_opd,        // Set group operand kind
   input wire logic [4:0] i_sel,      // Selector n or immediate selector
   input wire logic [3:0] i_cond,     // Branch condition code, 12 = always
   input wire logic [31:0] i_dst,     // Destination register value
   input wire logic [31:0] i_src,     // Source or immediate operand
   input wire logic [31:0] i_sp,      // Stack pointer
   input wire logic [31:0] i_sr,      // Status word
   input wire logic [31:0] i_pc_next, // Address of byte after instruction
   input wire logic [31:0] i_rel,     // Sign-extended displacement
   input wire logic [31:0] i_alu_res, // Result of move/add/sum/sub to PC
   input wire logic [3:0] i_alu_flags, // New N Z V C of that instruction
   input wire logic i_n,              // Negative flag
   input wire logic i_z,              // Zero flag
   input wire logic i_v,              // Overflow flag
   input wire logic i_c,              // Carry flag
   output logic o_rd_we,              // Destination write strobe
   output logic [31:0] o_rd_data,     // Destination write data
   output logic o_flag_we,            // Flag write strobe
   output logic [3:0] o_flags,        // New N Z V C
   output logic o_pc_we,              // PC load strobe
   output logic [31:0] o_pc_data,     // New PC value
   output logic o_m_clr,              // Clear cache-mode flag
   output logic o_fetch,              // Fetch operation selected
   output logic o_reserved            // Reserved encoding seen
);

   // Evaluate one of the twelve conditions, code 0..11 in table order
   function automatic logic cond_eval(input logic [3:0] code, input logic n,
                                      input logic z, input logic v, input logic c);
      logic r;
      r = 1'b0;
      unique case (code)
         4'h0: r = n | z;
         4'h1: r = ~(n | z);
         4'h2: r = n;
         4'h3: r = ~n;
         4'h4: r = c | z;
         4'h5: r = ~(c | z);
         4'h6: r = c;
         4'h7: r = ~c;
         4'h8: r = z;
         4'h9: r = ~z;
         4'ha: r = v;
         4'hb: r = ~v;
         default: r = 1'b1;
      endcase
      return r;
   endfunction : cond_eval

   function automatic logic [5:0] lzc(input logic [31:0] x);
      logic [5:0] cnt;
      logic found;
      cnt = 6'd32;
      found = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         if (!found && x[i]) begin
            cnt = 6'(31 - i);
            found = 1'b1;
         end
      end
      return cnt;
   endfunction : lzc

   // Selector classes of the set group with a register operand
   typedef enum logic [2:0] {
      CSB_SK_ADDR = 3'b000,
      CSB_SK_ONE  = 3'b001,
      CSB_SK_ZERO = 3'b010,
      CSB_SK_MONE = 3'b011,
      CSB_SK_LO   = 3'b100,
      CSB_SK_HI   = 3'b101,
      CSB_SK_RSV  = 3'b110
   } csb_selk_e;

   // Shared by the data path and the reserved strobe so both agree
   function automatic csb_selk_e sel_kind(input logic [4:0] sel);
      csb_selk_e k;
      k = CSB_SK_RSV;
      if (sel == CSB_SEL_ADDR) begin
         k = CSB_SK_ADDR;
      end else if (sel == CSB_SEL_ONE) begin
         k = CSB_SK_ONE;
      end else if (sel == CSB_SEL_ZERO) begin
         k = CSB_SK_ZERO;
      end else if (sel == CSB_SEL_MONE) begin
         k = CSB_SK_MONE;
      end else if (sel >= CSB_SEL_LO_FIRST && sel <= CSB_SEL_LO_LAST) begin
         k = CSB_SK_LO;
      end else if (sel >= CSB_SEL_HI_FIRST && sel <= CSB_SEL_HI_LAST) begin
         k = CSB_SK_HI;
      end
      return k;
   endfunction : sel_kind

   csb_selk_e set_kind;
   logic set_reg_sel;
   logic [3:0] byte_zero;

   logic rd_we_reg, rd_we_next;
   logic [31:0] rd_data_reg, rd_data_next;
   logic flag_we_reg, flag_we_next;
   logic [3:0] flags_reg, flags_next;
   logic pc_we_reg, pc_we_next;
   logic [31:0] pc_data_reg, pc_data_next;
   logic m_clr_reg, m_clr_next;
   logic fetch_reg, fetch_next;
   logic rsv_reg, rsv_next;

   logic [31:0] and_res;
   logic any_byte_zero;
   logic [31:0] frame_addr;
   logic frame_carry;
   logic [3:0] set_code;
   logic set_hold;
   logic br_taken;

   assign and_res = i_dst & i_src;
   for (genvar b = 0; b < 4; b++) begin : g_byte_zero
      assign byte_zero[b] = (i_dst[8*b +: 8] == 8'h00);
   end
   assign any_byte_zero = |byte_zero;
   assign frame_carry = i_sp[CSB_SP_CARRY_BIT] & ~i_sr[CSB_FP_MSB];
   assign frame_addr = {i_sp[31:CSB_SP_KEEP_LSB], i_sr[CSB_FP_MSB:CSB_FP_LSB], 2'b00}
                       + {22'h000000, frame_carry, 9'h000};
   assign set_code = 4'(i_sel[3:0] - 4'h4);
   assign set_hold = cond_eval(set_code, i_n, i_z, i_v, i_c);
   // branch taken on code 12 (always) or when the coded condition holds
   assign br_taken = (i_cond == CSB_BR_ALWAYS) | cond_eval(i_cond, i_n, i_z, i_v, i_c);

   assign set_kind = sel_kind(i_sel);
   assign set_reg_sel = i_valid & (i_op == CSB_OP_SETGRP) & (i_opd == CSB_OPD_REG);

   // Destination group
   always_comb begin
      rd_we_next = 1'b0;
      rd_data_next = rd_data_reg;
      if (i_valid && i_op == CSB_OP_LZC) begin
         rd_we_next = 1'b1;
         rd_data_next = {26'h0000000, lzc(i_src)};
      end else if (set_reg_sel) begin
         rd_we_next = (set_kind != CSB_SK_RSV);
         unique case (set_kind)
            CSB_SK_ADDR: rd_data_next = frame_addr;
            CSB_SK_ONE: rd_data_next = 32'h0000_0001;
            CSB_SK_ZERO: rd_data_next = 32'h0000_0000;
            CSB_SK_MONE: rd_data_next = 32'hffff_ffff;
            CSB_SK_LO: rd_data_next = {31'h00000000, set_hold};
            CSB_SK_HI: rd_data_next = {32{set_hold}};
            CSB_SK_RSV: rd_data_next = rd_data_reg;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_we_reg <= 1'b0;
         rd_data_reg <= CSB_DATA_RST;
      end else begin
         rd_we_reg <= rd_we_next;
         rd_data_reg <= rd_data_next;
      end
   end

   // Flag group; set group, leading zeros and branches never strobe it
   always_comb begin
      flag_we_next = 1'b0;
      flags_next = flags_reg;
      if (i_valid) begin
         unique case (i_op)
            CSB_OP_BITCMP: begin
               flag_we_next = 1'b1;
               flags_next = {i_n, (and_res == 32'h0000_0000), i_v, i_c};
            end
            CSB_OP_BITCMI: begin
               flag_we_next = 1'b1;
               if (i_sel == CSB_ANY_BYTE_ZERO_TEST_SEL) begin
                  flags_next = {i_n, any_byte_zero, i_v, i_c};
               end else begin
                  flags_next = {i_n, (and_res == 32'h0000_0000), i_v, i_c};
               end
            end
            CSB_OP_PCDEST: begin
               flag_we_next = 1'b1;
               flags_next = i_alu_flags;
            end
            default: begin
               flag_we_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flag_we_reg <= 1'b0;
         flags_reg <= 4'h0;
      end else begin
         flag_we_reg <= flag_we_next;
         flags_reg <= flags_next;
      end
   end

   // Program counter group
   always_comb begin
      pc_we_next = 1'b0;
      pc_data_next = pc_data_reg;
      m_clr_next = 1'b0;
      if (i_valid && i_op == CSB_OP_BRANCH && br_taken) begin
         pc_we_next = 1'b1;
         pc_data_next = i_pc_next + i_rel;
         m_clr_next = 1'b1;
      end else if (i_valid && i_op == CSB_OP_PCDEST) begin
         pc_we_next = 1'b1;
         pc_data_next = i_alu_res;
         m_clr_next = 1'b1;
      end
      // untaken branch keeps PC and M
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pc_we_reg <= 1'b0;
         pc_data_reg <= CSB_DATA_RST;
         m_clr_reg <= 1'b0;
      end else begin
         pc_we_reg <= pc_we_next;
         pc_data_reg <= pc_data_next;
         m_clr_reg <= m_clr_next;
      end
   end

   // Fetch and reserved strobes
   always_comb begin
      fetch_next = 1'b0;
      rsv_next = 1'b0;
      if (i_valid && i_op == CSB_OP_SETGRP) begin
         fetch_next = (i_opd == CSB_OPD_SR);
         rsv_next = (i_opd == CSB_OPD_PC) | (set_reg_sel & (set_kind == CSB_SK_RSV));
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fetch_reg <= 1'b0;
         rsv_reg <= 1'b0;
      end else begin
         fetch_reg <= fetch_next;
         rsv_reg <= rsv_next;
      end
   end

   assign o_rd_we = rd_we_reg;
   assign o_rd_data = rd_data_reg;
   assign o_flag_we = flag_we_reg;
   assign o_flags = flags_reg;
   assign o_pc_we = pc_we_reg;
   assign o_pc_data = pc_data_reg;
   assign o_m_clr = m_clr_reg;
   assign o_fetch = fetch_reg;
   assign o_reserved = rsv_reg;

endmodule : csb_exec
`default_nettype wire

/* src/csb_pkg.sv */
package csb_pkg;
   // Operation selector presented by the core's decode stage
   typedef enum logic [2:0] {
      CSB_OP_NONE   = 3'b000,
      CSB_OP_BITCMP = 3'b001,
      CSB_OP_BITCMI = 3'b010,
      CSB_OP_LZC    = 3'b011,
      CSB_OP_SETGRP = 3'b100,
      CSB_OP_BRANCH = 3'b101,
      CSB_OP_PCDEST = 3'b110
   } csb_op_e;

   // Operand kind of the set group
   typedef enum logic [1:0] {
      CSB_OPD_REG = 2'b00,
      CSB_OPD_SR  = 2'b01,
      CSB_OPD_PC  = 2'b10
   } csb_opd_e;

   localparam logic [3:0] CSB_BR_ALWAYS = 4'hc;
   localparam logic [4:0] CSB_SEL_ADDR = 5'h00;
   localparam logic [4:0] CSB_SEL_ONE = 5'h02;
   localparam logic [4:0] CSB_SEL_ZERO = 5'h03;
   localparam logic [4:0] CSB_SEL_MONE = 5'h12;
   localparam logic [4:0] CSB_SEL_LO_FIRST = 5'h04;
   localparam logic [4:0] CSB_SEL_LO_LAST = 5'h0f;
   localparam logic [4:0] CSB_SEL_HI_FIRST = 5'h14;
   localparam logic [4:0] CSB_SEL_HI_LAST = 5'h1f;
   localparam logic [4:0] CSB_ANY_BYTE_ZERO_TEST_SEL = 5'h00;
   localparam int CSB_FP_LSB = 25;
   localparam int CSB_FP_MSB = 31;
   localparam int CSB_SP_KEEP_LSB = 9;
   localparam int CSB_SP_CARRY_BIT = 8;
   localparam logic [31:0] CSB_DATA_RST = 32'h0000_0000;
endpackage : csb_pkg

/* testbench/csb_exec_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module csb_exec_properties
   import csb_pkg::*;
(
   input wire logic i_clk, i_rst_n, i_valid, i_z,
   input wire csb_op_e i_op,
   input wire csb_opd_e i_opd,
   input wire logic [4:0] i_sel,
   input wire logic [3:0] i_cond, i_alu_flags,
   input wire logic [31:0] i_dst, i_src, i_sp, i_sr, i_pc_next, i_rel,
   input wire logic o_rd_we, o_flag_we, o_pc_we, o_m_clr, o_fetch,
   input wire logic [3:0] o_flags,
   input wire logic [31:0] o_rd_data, o_pc_data
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic [31:0] frame_addr;
   logic any_zero;
   logic set_reg;
   assign frame_addr = {i_sp[31:9], i_sr[31:25], 2'b00} + {22'h0, i_sp[8] & ~i_sr[31], 9'h0};
   assign any_zero = (i_dst[31:24] == 8'h0) || (i_dst[23:16] == 8'h0) ||
      (i_dst[15:8] == 8'h0) || (i_dst[7:0] == 8'h0);
   assign set_reg = i_valid && i_op == CSB_OP_SETGRP && i_opd == CSB_OPD_REG;
   a_bitcmp_zflag: assert property (i_valid && i_op == CSB_OP_BITCMP |=>
      o_flag_we && o_flags[2] == ($past(i_dst & i_src) == 32'h0)) else $error("bit compare Z wrong");
   a_any_byte_zero_test_zflag: assert property (i_valid && i_op == CSB_OP_BITCMI &&
      i_sel == CSB_ANY_BYTE_ZERO_TEST_SEL |=> o_flags[2] == $past(any_zero)) else $error("byte zero Z wrong");
   a_lzc_keep_flags: assert property (i_valid && i_op == CSB_OP_LZC |=>
      o_rd_we && !o_flag_we) else $error("leading zero strobes wrong");
   a_frame_value: assert property (set_reg && i_sel == CSB_SEL_ADDR |=>
      o_rd_we && o_rd_data == $past(frame_addr)) else $error("frame address wrong");
   a_set_keep_flags: assert property (set_reg |=> !o_flag_we && !o_pc_we)
      else $error("set group touched flags");
   a_fetch_select: assert property (i_valid && i_op == CSB_OP_SETGRP &&
      i_opd == CSB_OPD_SR |=> o_fetch && !o_rd_we) else $error("fetch not selected");
   a_branch_taken: assert property (i_valid && i_op == CSB_OP_BRANCH &&
      i_cond == CSB_BR_ALWAYS |=> o_pc_we && o_m_clr && !o_flag_we &&
      o_pc_data == $past(i_pc_next + i_rel)) else $error("taken branch wrong");
   a_branch_untaken: assert property (i_valid && i_op == CSB_OP_BRANCH &&
      i_cond == 4'h8 && !i_z |=> !o_pc_we && !o_m_clr) else $error("untaken branch moved");
   a_pc_dest: assert property (i_valid && i_op == CSB_OP_PCDEST |=>
      o_pc_we && o_m_clr && o_flag_we && o_flags == $past(i_alu_flags)) else $error("pc dest wrong");
   cover property (i_valid && i_op == CSB_OP_BRANCH ##1 o_pc_we);
   cover property (set_reg && i_sel == CSB_SEL_HI_LAST ##1 o_rd_we);
   cover property (i_valid && i_op == CSB_OP_PCDEST ##1 o_flag_we);
endmodule : csb_exec_properties
bind csb_exec csb_exec_properties i_chk (.i_clk, .i_rst_n, .i_valid, .i_z, .i_op, .i_opd,
   .i_sel, .i_cond, .i_alu_flags, .i_dst, .i_src, .i_sp, .i_sr, .i_pc_next, .i_rel, .o_rd_we,
   .o_flag_we, .o_pc_we, .o_m_clr, .o_fetch, .o_flags, .o_rd_data, .o_pc_data);
`default_nettype wire

/* testbench/tb_csb_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_csb_exec
   import csb_pkg::*;
;
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_valid = 1'b0;
   logic i_n = 1'b0, i_z = 1'b0, i_v = 1'b0, i_c = 1'b0;
   csb_op_e i_op = CSB_OP_NONE;
   csb_opd_e i_opd = CSB_OPD_REG;
   logic [4:0] i_sel = 5'h00;
   logic [3:0] i_cond = 4'h0, i_alu_flags = 4'h0;
   logic [31:0] i_dst = 32'h0, i_src = 32'h0, i_sp = 32'h0, i_sr = 32'h0;
   logic [31:0] i_pc_next = 32'h0, i_rel = 32'h0, i_alu_res = 32'h0;
   logic o_rd_we, o_flag_we, o_pc_we, o_m_clr, o_fetch, o_reserved;
   logic [3:0] o_flags;
   logic [31:0] o_rd_data, o_pc_data;
   int n_mismatch = 0, n_compared = 0;
   localparam logic [31:0] DV [5] = '{32'h0011_2233, 32'h1100_2233, 32'h1122_0033,
      32'h1122_3300, 32'h8080_8080};
   // Last case wraps past the top of memory
   localparam logic [31:0] SPV [3] = '{32'h1234_5f00, 32'h1234_5f00, 32'hffff_ff00};
   localparam logic [31:0] SRV [3] = '{32'h0e00_0000, 32'hfe00_0000, 32'h7e00_0000};
   always #5 i_clk = ~i_clk;
   csb_exec i_dut (.i_clk, .i_rst_n, .i_valid, .i_op, .i_opd, .i_sel, .i_cond, .i_dst, .i_src,
      .i_sp, .i_sr, .i_pc_next, .i_rel, .i_alu_res, .i_alu_flags, .i_n, .i_z, .i_v, .i_c,
      .o_rd_we, .o_rd_data, .o_flag_we, .o_flags, .o_pc_we, .o_pc_data, .o_m_clr, .o_fetch,
      .o_reserved);
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit
   // Valid drops after one edge so each call is exactly one instruction
   task automatic issue(input csb_op_e op, input csb_opd_e opd, input logic [4:0] sel,
      input logic [3:0] cnd);
      @(negedge i_clk);
      i_valid = 1'b1;
      i_op = op;
      i_opd = opd;
      i_sel = sel;
      i_cond = cnd;
      @(negedge i_clk);
      i_valid = 1'b0;
   endtask : issue
   function automatic logic cond_ok(input logic [3:0] k);
      logic b;
      case (k[3:1])
         3'h0: b = i_n | i_z;
         3'h1: b = i_n;
         3'h2: b = i_c | i_z;
         3'h3: b = i_c;
         3'h4: b = i_z;
         3'h5: b = i_v;
         default: return 1'b1;
      endcase
      return b ^ k[0];
   endfunction : cond_ok
   function automatic logic [31:0] set_exp(input logic [4:0] s);
      if (s == 5'h02) return 32'h0000_0001;
      if (s == 5'h03) return 32'h0000_0000;
      if (s == 5'h12) return 32'hffff_ffff;
      if (s[4]) return {32{cond_ok(4'(s - 5'h14))}};
      return {31'h0, cond_ok(4'(s - 5'h04))};
   endfunction : set_exp
   task automatic give_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #100us;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      logic t;
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      i_rst_n = 1'b1;
      for (int f = 0; f < 16; f++) begin
         {i_n, i_z, i_v, i_c} = 4'(f);
         for (int s = 2; s < 32; s++) begin
            if (s != 16 && s != 17 && s != 19) begin
               issue(CSB_OP_SETGRP, CSB_OPD_REG, 5'(s), 4'h0);
               chk_word(o_rd_data, set_exp(5'(s)));
               chk_bit(o_flag_we, 1'b0);
            end
         end
         for (int k = 0; k < 13; k++) begin
            i_pc_next = 32'h0000_1000 + 32'(f);
            i_rel = f[0] ? 32'hffff_fff8 : 32'h0000_0040;
            issue(CSB_OP_BRANCH, CSB_OPD_REG, 5'h00, 4'(k));
            t = cond_ok(4'(k));
            chk_bit(o_pc_we, t);
            chk_bit(o_m_clr, t);
            chk_bit(o_flag_we, 1'b0);
            if (t) chk_word(o_pc_data, i_pc_next + i_rel);
         end
      end
      {i_n, i_z, i_v, i_c} = 4'hb;
      for (int j = 0; j < 15; j++) begin
         i_dst = DV[j % 5];
         i_src = DV[(j + 1) % 5];
         issue((j % 3 == 0) ? CSB_OP_BITCMP : CSB_OP_BITCMI, CSB_OPD_REG, 5'((j % 3) == 1), 4'h0);
         t = (j % 3 == 2) ? (i_dst[31:24] == 8'h0 || i_dst[23:16] == 8'h0 ||
            i_dst[15:8] == 8'h0 || i_dst[7:0] == 8'h0) : ((i_dst & i_src) == 32'h0);
         chk_word({28'h0, o_flags}, {28'h0, 1'b1, t, 2'b11});
         chk_bit(o_rd_we, 1'b0);
      end
      for (int k = 0; k < 33; k++) begin
         i_src = (k == 32) ? 32'h0 : (32'hffff_ffff >> k);
         issue(CSB_OP_LZC, CSB_OPD_REG, 5'h00, 4'h0);
         chk_word(o_rd_data, 32'(k));
      end
      for (int k = 0; k < 3; k++) begin
         i_sp = SPV[k];
         i_sr = SRV[k];
         issue(CSB_OP_SETGRP, CSB_OPD_REG, CSB_SEL_ADDR, 4'h0);
         chk_word(o_rd_data, {i_sp[31:9], i_sr[31:25], 2'b00} +
            ((i_sp[8] && !i_sr[31]) ? 32'h200 : 32'h0));
         chk_bit(o_flag_we, 1'b0);
      end
      issue(CSB_OP_SETGRP, CSB_OPD_SR, 5'h05, 4'h0);
      chk_bit(o_fetch, 1'b1);
      issue(CSB_OP_SETGRP, CSB_OPD_REG, 5'h01, 4'h0);
      chk_bit(o_reserved, 1'b1);
      chk_bit(o_rd_we, 1'b0);
      // PC destination only through implicit-branch operations
      i_alu_res = 32'h0000_2468;
      i_alu_flags = 4'h6;
      issue(CSB_OP_PCDEST, CSB_OPD_REG, 5'h00, 4'h0);
      chk_word(o_pc_data, 32'h0000_2468);
      chk_word({28'h0, o_flags}, 32'h0000_0006);
      give_verdict();
   end
endmodule : tb_csb_exec
`default_nettype wire
